// [hw/lsec_defs.vh]
// Purpose: Constants for the load/store event classifier
// Assumes: Included by every design file of the classifier
// Notes: Event numbers are 16 bits; bit indices address the strobe vector
`ifndef LSEC_DEFS_VH
`define LSEC_DEFS_VH

// Event numbers
`define LSEC_EVT_SIMD_VEC_LDST 16'h8084
`define LSEC_EVT_SIMD_VEC_LOAD 16'h8085
`define LSEC_EVT_SIMD_VEC_STORE 16'h8086
`define LSEC_EVT_PREFETCH 16'h8087
`define LSEC_EVT_GPR_ACCESS 16'h8088
`define LSEC_EVT_GPR_LOAD 16'h8089
`define LSEC_EVT_GPR_STORE 16'h808a
`define LSEC_EVT_GPR_PREFETCH 16'h808b
`define LSEC_EVT_FP_ACCESS 16'h808c
`define LSEC_EVT_FP_LOAD 16'h808d
`define LSEC_EVT_FP_STORE 16'h808e
`define LSEC_EVT_WREG_ACCESS 16'h8090
`define LSEC_EVT_WREG_LOAD 16'h8091
`define LSEC_EVT_WREG_STORE 16'h8092
`define LSEC_EVT_PREG_ACCESS 16'h8094
`define LSEC_EVT_PREG_LOAD 16'h8095
`define LSEC_EVT_PREG_STORE 16'h8096
`define LSEC_EVT_VREG_ACCESS 16'h8098
`define LSEC_EVT_VREG_LOAD 16'h8099
`define LSEC_EVT_VREG_STORE 16'h809a
`define LSEC_EVT_CONTIG_ACCESS 16'h809c
`define LSEC_EVT_CONTIG_LOAD 16'h809d
`define LSEC_EVT_CONTIG_STORE 16'h809e
`define LSEC_EVT_CONTIG_PREFETCH 16'h809f
`define LSEC_EVT_NT_ACCESS 16'h80a0
`define LSEC_EVT_NT_LOAD 16'h80a1
`define LSEC_EVT_NT_STORE 16'h80a2
`define LSEC_EVT_MANY_ACCESS 16'h80a4
`define LSEC_EVT_MANY_LOAD 16'h80a5
`define LSEC_EVT_MANY_STORE 16'h80a6
`define LSEC_EVT_MWIDE_ACCESS 16'h80a8
`define LSEC_EVT_MWIDE_LOAD 16'h80a9
`define LSEC_EVT_MWIDE_STORE 16'h80aa
`define LSEC_EVT_GATHER_SCATTER 16'h80ac

// Strobe vector layout
`define LSEC_NUM_EVENTS 34
`define LSEC_B_SIMD_VEC_LDST 0
`define LSEC_B_SIMD_VEC_LOAD 1
`define LSEC_B_SIMD_VEC_STORE 2
`define LSEC_B_PREFETCH 3
`define LSEC_B_GPR_ACCESS 4
`define LSEC_B_GPR_LOAD 5
`define LSEC_B_GPR_STORE 6
`define LSEC_B_GPR_PREFETCH 7
`define LSEC_B_FP_ACCESS 8
`define LSEC_B_FP_LOAD 9
`define LSEC_B_FP_STORE 10
`define LSEC_B_WREG_ACCESS 11
`define LSEC_B_WREG_LOAD 12
`define LSEC_B_WREG_STORE 13
`define LSEC_B_PREG_ACCESS 14
`define LSEC_B_PREG_LOAD 15
`define LSEC_B_PREG_STORE 16
`define LSEC_B_VREG_ACCESS 17
`define LSEC_B_VREG_LOAD 18
`define LSEC_B_VREG_STORE 19
`define LSEC_B_CONTIG_ACCESS 20
`define LSEC_B_CONTIG_LOAD 21
`define LSEC_B_CONTIG_STORE 22
`define LSEC_B_CONTIG_PREFETCH 23
`define LSEC_B_NT_ACCESS 24
`define LSEC_B_NT_LOAD 25
`define LSEC_B_NT_STORE 26
`define LSEC_B_MANY_ACCESS 27
`define LSEC_B_MANY_LOAD 28
`define LSEC_B_MANY_STORE 29
`define LSEC_B_MWIDE_ACCESS 30
`define LSEC_B_MWIDE_LOAD 31
`define LSEC_B_MWIDE_STORE 32
`define LSEC_B_GATHER_SCATTER 33

// Operation class codes on op_class
`define LSEC_CLS_W 4
`define LSEC_CLS_NONE 4'h0
`define LSEC_CLS_GPR 4'h1
`define LSEC_CLS_LINE_ZERO 4'h2
`define LSEC_CLS_SCALAR_PRF 4'h3
`define LSEC_CLS_FP_SCALAR 4'h4
`define LSEC_CLS_SIMD_SINGLE 4'h5
`define LSEC_CLS_SIMD_REPL 4'h6
`define LSEC_CLS_WREG 4'h7
`define LSEC_CLS_PREG 4'h8
`define LSEC_CLS_VREG 4'h9
`define LSEC_CLS_CONTIG 4'ha
`define LSEC_CLS_CONTIG_REPL 4'hb
`define LSEC_CLS_NT 4'hc
`define LSEC_CLS_MULTI_SIMD 4'hd
`define LSEC_CLS_MULTI_WIDE 4'he
`define LSEC_CLS_GATHER 4'hf

// Access kind codes on op_kind
`define LSEC_KIND_W 2
`define LSEC_KIND_LOAD 2'h0
`define LSEC_KIND_STORE 2'h1
`define LSEC_KIND_PRF 2'h2

`endif

// [hw/lsec_decode.v]
// Purpose: Decode class and kind of one operation into one-hot flags
// Assumes: Inputs come from logic on the same clock
// Notes: Purely combinational
`default_nettype none
`include "lsec_defs.vh"

module lsec_decode (
  // Operation
  input wire [`LSEC_CLS_W-1:0] op_class,
  input wire [`LSEC_KIND_W-1:0] op_kind,
  // Flags
  output wire [15:0] cls_hot,
  output wire is_load,
  output wire is_store,
  output wire is_prf
);

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_hot
      // Compared at genvar width so no bits are cut
      assign cls_hot[g] = ({{(32-`LSEC_CLS_W){1'b0}}, op_class} == g);
    end
  endgenerate

  assign is_load = (op_kind == `LSEC_KIND_LOAD);
  assign is_store = (op_kind == `LSEC_KIND_STORE);
  assign is_prf = (op_kind == `LSEC_KIND_PRF);

endmodule
`default_nettype wire

// [hw/lsec_event_encode.v]
// Purpose: Encode the lowest asserted strobe into its 16-bit event number
// Assumes: Result registered by the instantiating module
// Notes: Debug aid; the full strobe vector remains authoritative
`default_nettype none
`include "lsec_defs.vh"

module lsec_event_encode (
  // Strobes
  input wire [`LSEC_NUM_EVENTS-1:0] strobes,
  // Result
  output reg [15:0] event_num,
  output wire any_hit
);

  // Lookup of event numbers by strobe index
  function [15:0] num_of;
    input integer idx;
    begin
      case (idx)
        `LSEC_B_SIMD_VEC_LDST: num_of = `LSEC_EVT_SIMD_VEC_LDST;
        `LSEC_B_SIMD_VEC_LOAD: num_of = `LSEC_EVT_SIMD_VEC_LOAD;
        `LSEC_B_SIMD_VEC_STORE: num_of = `LSEC_EVT_SIMD_VEC_STORE;
        `LSEC_B_PREFETCH: num_of = `LSEC_EVT_PREFETCH;
        `LSEC_B_GPR_ACCESS: num_of = `LSEC_EVT_GPR_ACCESS;
        `LSEC_B_GPR_LOAD: num_of = `LSEC_EVT_GPR_LOAD;
        `LSEC_B_GPR_STORE: num_of = `LSEC_EVT_GPR_STORE;
        `LSEC_B_GPR_PREFETCH: num_of = `LSEC_EVT_GPR_PREFETCH;
        `LSEC_B_FP_ACCESS: num_of = `LSEC_EVT_FP_ACCESS;
        `LSEC_B_FP_LOAD: num_of = `LSEC_EVT_FP_LOAD;
        `LSEC_B_FP_STORE: num_of = `LSEC_EVT_FP_STORE;
        `LSEC_B_WREG_ACCESS: num_of = `LSEC_EVT_WREG_ACCESS;
        `LSEC_B_WREG_LOAD: num_of = `LSEC_EVT_WREG_LOAD;
        `LSEC_B_WREG_STORE: num_of = `LSEC_EVT_WREG_STORE;
        `LSEC_B_PREG_ACCESS: num_of = `LSEC_EVT_PREG_ACCESS;
        `LSEC_B_PREG_LOAD: num_of = `LSEC_EVT_PREG_LOAD;
        `LSEC_B_PREG_STORE: num_of = `LSEC_EVT_PREG_STORE;
        `LSEC_B_VREG_ACCESS: num_of = `LSEC_EVT_VREG_ACCESS;
        `LSEC_B_VREG_LOAD: num_of = `LSEC_EVT_VREG_LOAD;
        `LSEC_B_VREG_STORE: num_of = `LSEC_EVT_VREG_STORE;
        `LSEC_B_CONTIG_ACCESS: num_of = `LSEC_EVT_CONTIG_ACCESS;
        `LSEC_B_CONTIG_LOAD: num_of = `LSEC_EVT_CONTIG_LOAD;
        `LSEC_B_CONTIG_STORE: num_of = `LSEC_EVT_CONTIG_STORE;
        `LSEC_B_CONTIG_PREFETCH: num_of = `LSEC_EVT_CONTIG_PREFETCH;
        `LSEC_B_NT_ACCESS: num_of = `LSEC_EVT_NT_ACCESS;
        `LSEC_B_NT_LOAD: num_of = `LSEC_EVT_NT_LOAD;
        `LSEC_B_NT_STORE: num_of = `LSEC_EVT_NT_STORE;
        `LSEC_B_MANY_ACCESS: num_of = `LSEC_EVT_MANY_ACCESS;
        `LSEC_B_MANY_LOAD: num_of = `LSEC_EVT_MANY_LOAD;
        `LSEC_B_MANY_STORE: num_of = `LSEC_EVT_MANY_STORE;
        `LSEC_B_MWIDE_ACCESS: num_of = `LSEC_EVT_MWIDE_ACCESS;
        `LSEC_B_MWIDE_LOAD: num_of = `LSEC_EVT_MWIDE_LOAD;
        `LSEC_B_MWIDE_STORE: num_of = `LSEC_EVT_MWIDE_STORE;
        `LSEC_B_GATHER_SCATTER: num_of = `LSEC_EVT_GATHER_SCATTER;
        default: num_of = 16'h0000;
      endcase
    end
  endfunction

  integer i;
  always @* begin
    event_num = 16'h0000;
    // Highest index scanned first so the lowest wins
    for (i = `LSEC_NUM_EVENTS - 1; i >= 0; i = i - 1) begin
      if (strobes[i]) begin
        event_num = num_of(i);
      end
    end
  end

  assign any_hit = |strobes;

endmodule
`default_nettype wire

// [hw/lsec_classifier.v]
// Purpose: Sort speculatively executed memory operations into counting events
// Assumes: One operation per cycle, qualified by op_valid, same clock domain
// Notes: Strobes are registered; one operation may pulse many events
// Functional notes
// - Combined event: all vector/SIMD loads and stores, plus every prefetch.
// - Vector/SIMD loads and stores each get their own event.
// - Prefetch event covers scalar and vector prefetch instructions.
// - GPR access event: GPR loads, GPR stores, scalar prefetch.
// - Line zeroing counting in GPR events fixed by a design parameter.
// - GPR loads and GPR stores counted under separate events.
// - GPR prefetch event counts only the scalar prefetch instruction.
// - FP/SIMD register event: scalar single/pair, SIMD single-structure and replicate.
// - FP/SIMD register accesses split into load and store events.
// - Whole-register vector transfers: combined, load and store events.
// - Predicate register transfers: combined, load and store events.
// - Vector register transfers: combined, load and store events.
// - Contiguous event: predicated contiguous loads, stores, prefetches, replicate loads.
// - Contiguous load event includes replicate and quadword replicate loads.
// - Contiguous store event counts predicated contiguous stores.
// - Contiguous prefetch event counts predicated contiguous prefetches.
// - Non-temporal contiguous accesses: combined, load and store events.
// - Multi-vector structure accesses, any width: combined, load and store.
// - Multi-vector structure accesses, wide only: combined, load and store.
// - Gather/scatter event counts gathers, scatters and gather prefetches.
// - Events count at speculative execution, regardless of later completion.
`default_nettype none
`include "lsec_defs.vh"

module lsec_classifier #(
  parameter LINE_ZERO_COUNTS = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Operation from the issue stage
  input wire op_valid,
  input wire [`LSEC_CLS_W-1:0] op_class,
  input wire [`LSEC_KIND_W-1:0] op_kind,
  // Event strobes toward the counters
  output reg [`LSEC_NUM_EVENTS-1:0] event_strobe_q,
  output wire [15:0] first_event_num,
  output wire event_any
);

  wire [15:0] hot;
  wire ld;
  wire st;
  wire pf;
  reg [`LSEC_NUM_EVENTS-1:0] event_strobe_d;
  wire [15:0] first_num_d;
  wire any_d;
  reg [15:0] first_num_q;
  reg any_q;

  lsec_decode u_decode (
    .op_class(op_class),
    .op_kind(op_kind),
    .cls_hot(hot),
    .is_load(ld),
    .is_store(st),
    .is_prf(pf)
  );

  // Class groupings
  wire c_gpr = hot[`LSEC_CLS_GPR];
  // Line zeroing only as a store; other kind codes are refused
  wire c_zero = hot[`LSEC_CLS_LINE_ZERO] & st & (LINE_ZERO_COUNTS != 0);
  wire c_sprf = hot[`LSEC_CLS_SCALAR_PRF] & pf;
  wire c_fps = hot[`LSEC_CLS_FP_SCALAR];
  wire c_sing = hot[`LSEC_CLS_SIMD_SINGLE];
  wire c_srep = hot[`LSEC_CLS_SIMD_REPL];
  wire c_wreg = hot[`LSEC_CLS_WREG];
  wire c_preg = hot[`LSEC_CLS_PREG];
  wire c_vreg = hot[`LSEC_CLS_VREG];
  wire c_cont = hot[`LSEC_CLS_CONTIG];
  wire c_crep = hot[`LSEC_CLS_CONTIG_REPL];
  wire c_nt = hot[`LSEC_CLS_NT];
  wire c_msimd = hot[`LSEC_CLS_MULTI_SIMD];
  wire c_mwide = hot[`LSEC_CLS_MULTI_WIDE];
  wire c_gath = hot[`LSEC_CLS_GATHER];

  // Every vector or SIMD memory class
  wire c_vec = c_fps | c_sing | c_srep | c_wreg | c_preg | c_vreg | c_cont | c_crep |
    c_nt | c_msimd | c_mwide | c_gath;
  // Vector prefetch forms; replicate classes never prefetch
  wire v_prf = pf & (c_cont | c_gath);
  wire ldst = ld | st;
  // Replicate classes have no store form, so a store code there counts nowhere
  wire rep = c_srep | c_crep;
  wire v_ld = c_vec & ld;
  wire v_st = c_vec & st & ~rep;

  always @* begin
    event_strobe_d = {`LSEC_NUM_EVENTS{1'b0}};
    // Valid means issued; completion is not waited for
    if (op_valid) begin
      event_strobe_d[`LSEC_B_SIMD_VEC_LDST] = v_ld | v_st | c_sprf | v_prf;
      event_strobe_d[`LSEC_B_SIMD_VEC_LOAD] = v_ld;
      event_strobe_d[`LSEC_B_SIMD_VEC_STORE] = v_st;
      event_strobe_d[`LSEC_B_PREFETCH] = c_sprf | v_prf;
      // Line zeroing is a store only
      event_strobe_d[`LSEC_B_GPR_ACCESS] = (c_gpr & ldst) | c_sprf | c_zero;
      event_strobe_d[`LSEC_B_GPR_LOAD] = c_gpr & ld;
      event_strobe_d[`LSEC_B_GPR_STORE] = (c_gpr & st) | c_zero;
      event_strobe_d[`LSEC_B_GPR_PREFETCH] = c_sprf;
      event_strobe_d[`LSEC_B_FP_ACCESS] = (c_fps | c_sing) & ldst | (c_srep & ld);
      event_strobe_d[`LSEC_B_FP_LOAD] = (c_fps | c_sing | c_srep) & ld;
      event_strobe_d[`LSEC_B_FP_STORE] = (c_fps | c_sing) & st;
      event_strobe_d[`LSEC_B_WREG_ACCESS] = c_wreg & ldst;
      event_strobe_d[`LSEC_B_WREG_LOAD] = c_wreg & ld;
      event_strobe_d[`LSEC_B_WREG_STORE] = c_wreg & st;
      event_strobe_d[`LSEC_B_PREG_ACCESS] = c_preg & ldst;
      event_strobe_d[`LSEC_B_PREG_LOAD] = c_preg & ld;
      event_strobe_d[`LSEC_B_PREG_STORE] = c_preg & st;
      event_strobe_d[`LSEC_B_VREG_ACCESS] = c_vreg & ldst;
      event_strobe_d[`LSEC_B_VREG_LOAD] = c_vreg & ld;
      event_strobe_d[`LSEC_B_VREG_STORE] = c_vreg & st;
      event_strobe_d[`LSEC_B_CONTIG_ACCESS] = (c_cont & (ldst | pf)) | (c_crep & ld);
      event_strobe_d[`LSEC_B_CONTIG_LOAD] = (c_cont | c_crep) & ld;
      event_strobe_d[`LSEC_B_CONTIG_STORE] = c_cont & st;
      event_strobe_d[`LSEC_B_CONTIG_PREFETCH] = c_cont & pf;
      event_strobe_d[`LSEC_B_NT_ACCESS] = c_nt & ldst;
      event_strobe_d[`LSEC_B_NT_LOAD] = c_nt & ld;
      event_strobe_d[`LSEC_B_NT_STORE] = c_nt & st;
      event_strobe_d[`LSEC_B_MANY_ACCESS] = (c_msimd | c_mwide) & ldst;
      event_strobe_d[`LSEC_B_MANY_LOAD] = (c_msimd | c_mwide) & ld;
      event_strobe_d[`LSEC_B_MANY_STORE] = (c_msimd | c_mwide) & st;
      event_strobe_d[`LSEC_B_MWIDE_ACCESS] = c_mwide & ldst;
      event_strobe_d[`LSEC_B_MWIDE_LOAD] = c_mwide & ld;
      event_strobe_d[`LSEC_B_MWIDE_STORE] = c_mwide & st;
      event_strobe_d[`LSEC_B_GATHER_SCATTER] = c_gath & (ldst | pf);
    end
  end

  // Registered so counters see clean one-cycle pulses
  always @(posedge clk) begin
    if (rst) begin
      event_strobe_q <= {`LSEC_NUM_EVENTS{1'b0}};
      first_num_q <= 16'h0000;
      any_q <= 1'b0;
    end else begin
      event_strobe_q <= event_strobe_d;
      first_num_q <= first_num_d;
      any_q <= any_d;
    end
  end

  // Encoded ahead of the register so the debug outputs come from flip-flops
  lsec_event_encode u_encode (
    .strobes(event_strobe_d),
    .event_num(first_num_d),
    .any_hit(any_d)
  );

  assign first_event_num = first_num_q;
  assign event_any = any_q;

endmodule
`default_nettype wire

// [sim/lsec_classifier_checker.sv]
// Purpose: Port-level checks on the load/store event classifier
// Assumes: Bound to every classifier instance
// Notes: Samples a few classes; the bench compares every class
`default_nettype none
module lsec_classifier_checker #(
  parameter LINE_ZERO_COUNTS = 1
) (
  // Clock, reset and operation
  input wire logic clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [3:0] op_class,
  input wire logic [1:0] op_kind,
  // Outputs
  input wire logic [33:0] event_strobe_q,
  input wire logic [15:0] first_event_num,
  input wire logic event_any
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [33:0] s = event_strobe_q;
  wire [2:0] lz = (LINE_ZERO_COUNTS != 0) ? 3'b101 : 3'b000;
  sequence s_op(logic [3:0] c, logic [1:0] k);
    op_valid && op_class == c && op_kind == k;
  endsequence
  property p_gpr_load; s_op(4'h1, 2'h0) |=> s[6:4] == 3'b011; endproperty
  a_gpr_load: assert property (p_gpr_load) else $error("gpr load");
  property p_gpr_store; s_op(4'h1, 2'h1) |=> s[6:4] == 3'b101; endproperty
  a_gpr_store: assert property (p_gpr_store) else $error("gpr store");
  property p_line_zero; s_op(4'h2, 2'h1) |=> s[6:4] == lz; endproperty
  a_line_zero: assert property (p_line_zero) else $error("line zero");
  property p_scalar_prf; s_op(4'h3, 2'h2) |=> s[7:3] == 5'h13 && s[0]; endproperty
  a_scalar_prf: assert property (p_scalar_prf) else $error("scalar prf");
  property p_prf_src; s[7] |-> $past(op_valid) && $past(op_class) == 4'h3; endproperty
  a_prf_src: assert property (p_prf_src) else $error("gpr prefetch source");
  property p_vec_split; (s[1] || s[2]) |-> s[0] && !(s[1] && s[2]); endproperty
  a_vec_split: assert property (p_vec_split) else $error("vector split");
  property p_wreg; s_op(4'h7, 2'h1) |=> s[13:11] == 3'b101 && s[2]; endproperty
  a_wreg: assert property (p_wreg) else $error("whole reg store");
  property p_repl; s_op(4'hb, 2'h0) |=> s[21:20] == 2'b11 && s[1]; endproperty
  a_repl: assert property (p_repl) else $error("replicate load");
  property p_gather; s_op(4'hf, 2'h2) |=> s[33] && s[3] && s[0]; endproperty
  a_gather: assert property (p_gather) else $error("gather prefetch");
  // Pulse must end once the issue stage goes quiet
  property p_pulse;
    s_op(4'he, 2'h0) ##1 !op_valid |-> s[31] && s[28] && event_any ##1 s == 34'h0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("multi load pulse");
  property p_first; s[3:0] == 4'h0 && s[4] |-> first_event_num == 16'h8088; endproperty
  a_first: assert property (p_first) else $error("first event number");
endmodule
`default_nettype wire

// [sim/lsec_counter_model.sv]
// Purpose: Event counter bank standing behind the classifier
// Assumes: Strobes are one-cycle pulses on clk
// Notes: 16-bit counts wrap; no commit input, so every strobe counts
`default_nettype none
module lsec_counter_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strobes in, counts out
  input wire logic [33:0] strobes,
  output logic [33:0][15:0] counts
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    for (int i = 0; i < 34; i++) begin
      if (rst) counts[i] <= 16'h0;
      else if (strobes[i]) counts[i] <= counts[i] + 16'h1;
    end
  end
endmodule
`default_nettype wire

// [sim/ldst_event_classifier_tb_top.sv]
// Purpose: Self-checking bench for the load/store event classifier
// Assumes: Design, counter model and checker compiled first
// Notes: Class/kind pairs whose counting is unsettled stay out of stimulus
`default_nettype none
module ldst_event_classifier_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic [3:0] op_class = 4'h0;
  logic [1:0] op_kind = 2'h3;
  wire [33:0] strb;
  wire [33:0] strb0;
  wire [15:0] first_num;
  wire any_ev;
  wire [33:0][15:0] cnt;
  logic [7:0] notes [$];
  int exp_cnt [34] = '{default: 0};
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] evlo [34] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c,
    8'h8d, 8'h8e, 8'h90, 8'h91, 8'h92, 8'h94, 8'h95, 8'h96, 8'h98, 8'h99, 8'h9a, 8'h9c, 8'h9d,
    8'h9e, 8'h9f, 8'ha0, 8'ha1, 8'ha2, 8'ha4, 8'ha5, 8'ha6, 8'ha8, 8'ha9, 8'haa, 8'hac};
  always #5 clk = ~clk;
  lsec_classifier lsec_classifier_i (.clk(clk), .rst(rst), .op_valid(op_valid),
    .op_class(op_class), .op_kind(op_kind), .event_strobe_q(strb),
    .first_event_num(first_num), .event_any(any_ev));
  lsec_classifier #(.LINE_ZERO_COUNTS(0)) lsec_classifier_lz0_i (.clk(clk), .rst(rst),
    .op_valid(op_valid), .op_class(op_class), .op_kind(op_kind), .event_strobe_q(strb0),
    .first_event_num(), .event_any());
  lsec_counter_model lsec_counter_model_i (.clk(clk), .rst(rst), .strobes(strb), .counts(cnt));
  // Note layout: {rst, valid, class, kind}
  function automatic logic [33:0] exp_of(input logic [7:0] n, input logic lz);
    logic [33:0] e;
    logic ld, st, pf, a, vec;
    logic [2:0] t;
    ld = n[1:0] == 2'h0;
    st = n[1:0] == 2'h1;
    pf = n[1:0] == 2'h2;
    a = ld | st;
    t = {st, ld, a};
    e = '0;
    vec = a;
    case (n[5:2])
      4'h1: begin e[6:4] = t; vec = 1'b0; end
      4'h2: begin e[6:4] = {st & lz, 1'b0, st & lz}; vec = 1'b0; end
      4'h3: begin e[7:3] = {pf, 2'b00, pf, pf}; vec = pf; end
      4'h4, 4'h5: e[10:8] = t;
      4'h6: begin e[9:8] = {ld, ld}; vec = ld; end
      4'h7: e[13:11] = t;
      4'h8: e[16:14] = t;
      4'h9: e[19:17] = t;
      4'ha: begin e[23:20] = {pf, t[2:1], a | pf}; e[3] = pf; vec = a | pf; end
      4'hb: begin e[21:20] = {ld, ld}; vec = ld; end
      4'hc: e[26:24] = t;
      4'hd: e[29:27] = t;
      4'he: begin e[29:27] = t; e[32:30] = t; end
      4'hf: begin e[33] = a | pf; e[3] = pf; vec = a | pf; end
      default: vec = 1'b0;
    endcase
    if (vec) e[2:0] = {st, ld, 1'b1};
    if (n[7] || !n[6]) e = '0;
    return e;
  endfunction
  function automatic logic [1:0] legal_k(input logic [3:0] c, input logic [1:0] k);
    if (c == 4'h2 && k != 2'h3) return 2'h1;
    if (c == 4'h3 && k != 2'h3) return 2'h2;
    return k;
  endfunction
  task bad(input string m);
    err_total++;
    $display("BAD %0t %s", $time, m);
  endtask
  task send(input logic r, input logic v, input logic [3:0] c, input logic [1:0] k);
    @(posedge clk);
    rst <= r;
    op_valid <= v;
    op_class <= c;
    op_kind <= k;
    notes.push_back({r, v, c, k});
  endtask
  // Scalar FP transfers count in the combined vector events by design choice
  task automatic check(input logic [7:0] n);
    logic [33:0] e;
    logic [15:0] f;
    e = exp_of(n, 1'b1);
    f = 16'h0;
    for (int i = 33; i >= 0; i--) if (e[i]) f = {8'h80, evlo[i]};
    n_compared += 4;
    if (strb !== e) bad("strobes");
    if (strb0 !== exp_of(n, 1'b0)) bad("strobes, no line zero");
    if (first_num !== f) bad("first event number");
    if (any_ev !== (e != '0)) bad("event any");
    for (int i = 0; i < 34; i++) exp_cnt[i] = n[7] ? 0 : exp_cnt[i] + e[i];
  endtask
  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Result of a note shows one cycle after its op is taken
  always @(negedge clk) if (notes.size() > 1) check(notes.pop_front());
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      bad("timeout");
      summarize();
    end
  end
  initial begin
    logic [3:0] rc;
    logic [1:0] rk;
    void'($urandom(52));
    repeat (16) send(1'b1, 1'b1, 4'h1, 2'h0);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      for (int k = 0; k < 4; k++) begin
        rc = c;
        rk = legal_k(rc, k);
        repeat (2) send(1'b0, 1'b1, rc, rk);
        send(1'b0, 1'b0, rc, rk);
      end
    end
    $display("test sweep done");
    send(1'b0, 1'b1, 4'he, 2'h0);
    send(1'b1, 1'b1, 4'hf, 2'h2);
    send(1'b1, 1'b1, 4'h5, 2'h1);
    send(1'b0, 1'b1, 4'h7, 2'h1);
    $display("test mid reset done");
    repeat (3000) begin
      rc = $urandom;
      rk = $urandom;
      send(1'b0, $urandom_range(0, 3) != 0, rc, legal_k(rc, rk));
    end
    $display("test random done");
    repeat (4) send(1'b0, 1'b0, 4'h0, 2'h3);
    @(negedge clk);
    for (int i = 0; i < 34; i++) begin
      n_compared++;
      if (cnt[i] !== exp_cnt[i][15:0]) bad("event count");
    end
    $display("test counts done");
    summarize();
  end
endmodule
bind lsec_classifier lsec_classifier_checker #(.LINE_ZERO_COUNTS(LINE_ZERO_COUNTS)) chk_i (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_class(op_class), .op_kind(op_kind),
  .event_strobe_q(event_strobe_q), .first_event_num(first_event_num), .event_any(event_any));
`default_nettype wire
